// *** shared/mbid_pkg.sv ***
/*
 Constants, field layout and carrier types for the microcore branch and
 interrupt-return decoder. Assumes a 16-bit instruction word and a
 10-bit code RAM address.
*/
package mbid_pkg;

    localparam int          CODE_W        = 10;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_CTRL0     = 10'h101;
    localparam logic [9:0]  IDX_CTRL1     = 10'h102;
    localparam logic [9:0]  IDX_RESTART0  = 10'h10a;
    localparam logic [9:0]  IDX_RESTART1  = 10'h10b;
    localparam logic [9:0]  IDX_IRQ0      = 10'h10f;
    localparam logic [9:0]  IDX_IRQ1      = 10'h110;

    localparam logic [15:0] RST_CTRL      = 16'h0000;
    localparam logic [15:0] RST_RESTART   = 16'h0000;
    localparam logic [15:0] RST_IRQ       = 16'h0000;
    localparam logic [1:0]  RST_POLICY    = 2'h0;

    localparam logic [1:0]  POLICY_NONE   = 2'h0;
    localparam logic [1:0]  POLICY_CONT   = 2'h2;
    localparam logic [1:0]  POLICY_RSTRT  = 2'h3;

    // Opcode patterns
    localparam logic [13:0] PAT_POLICY    = 14'h0d6b;
    localparam logic [13:0] PAT_EXIT      = 14'h0d66;
    localparam logic [6:0]  PAT_AFAR      = 7'h1d;
    localparam logic [3:0]  PAT_AFAR_LO   = 4'h5;
    localparam logic [6:0]  PAT_ANEAR     = 7'h12;
    localparam logic [5:0]  PAT_CFAR      = 6'h0f;
    localparam logic [3:0]  PAT_CFAR_LO   = 4'h4;
    localparam logic [5:0]  PAT_CNEAR     = 6'h08;

    // Field positions
    localparam int          F_SEL_LSB     = 5;
    localparam int          F_OP1_BIT     = 4;
    localparam int          F_POL_BIT     = 9;
    localparam int          F_RESUME_BIT  = 1;
    localparam int          F_FLUSH_BIT   = 0;
    localparam int          F_OFF_W       = 5;

    typedef struct packed {
        logic              valid;
        logic [15:0]       word;
        logic [CODE_W-1:0] addr;
    } mbid_instr_s;

    // ALU condition register, field order is the selector code 15..0
    typedef struct packed {
        logic shiftCarry;
        logic convSign;
        logic carry;
        logic posOnlyArith;
        logic noAddSat;
        logic maskAllZeros;
        logic maskAllOnes;
        logic mulOverflow;
        logic mulLoss;
        logic zeroResult;
        logic resultSign;
        logic unsUnderflow;
        logic unsOverflow;
        logic sgnUnderflow;
        logic sgnOverflow;
        logic opDone;
    } mbid_alu_cond_s;

    typedef struct packed {
        logic [1:0]        policy;
        logic [15:0]       irqState;
        logic [15:0]       ctrlBits;
        logic [15:0]       restartAddr;
        logic              pcLoad;
        logic [CODE_W-1:0] pcNext;
        logic              flush;
        logic              retTaken;
        logic              wrPend;
        logic [9:0]        wrIdx;
        logic [31:0]       hrdata;
        logic              hready;
    } mbid_state_s;

endpackage : mbid_pkg

// *** rtl/mbid_branch_irq_decode.sv ***
/*
 Branch and interrupt-return execution for one microcore: return
 policy, interrupt exit, ALU and control-register jumps, plus an
 AHB-Lite slave for the core's control, restart and interrupt state.
 Assumes the core presents one instruction per valid cycle and
 follows pcNext whenever pcLoad pulses.
*/
module mbid_branch_irq_decode #(
    parameter bit CORE_SEL = 1'b0
) (
    input  wire logic                                  clock,
    input  wire logic                                  reset,
    input  wire logic                                  hsel,
    input  wire logic [31:0]                           haddr,
    input  wire logic [1:0]                            htrans,
    input  wire logic                                  hwrite,
    input  wire logic [2:0]                            hsize,
    input  wire logic [31:0]                           hwdata,
    input  wire logic                                  hready,
    output logic                                       hreadyout,
    output logic                                       hresp,
    output logic [31:0]                                hrdata,
    input  wire mbid_pkg::mbid_instr_s                 instr,
    input  wire mbid_pkg::mbid_alu_cond_s              aluCond,
    input  wire logic [1:0][mbid_pkg::CODE_W-1:0]      jumpRegs,
    input  wire logic                                  irqReturnReq,
    input  wire logic                                  irqEnter,
    input  wire logic [15:0]                           irqEnterState,
    output logic                                       pcLoad,
    output logic [mbid_pkg::CODE_W-1:0]                pcNext,
    output logic                                       queueFlush,
    output logic                                       returnTaken,
    output logic [1:0]                                 returnPolicy,
    output logic [15:0]                                controlBits
);

    localparam logic [9:0] CTRL_IDX = CORE_SEL ? mbid_pkg::IDX_CTRL1
                                               : mbid_pkg::IDX_CTRL0;
    localparam logic [9:0] RST_IDX  = CORE_SEL ? mbid_pkg::IDX_RESTART1
                                               : mbid_pkg::IDX_RESTART0;
    localparam logic [9:0] IRQ_IDX  = CORE_SEL ? mbid_pkg::IDX_IRQ1
                                               : mbid_pkg::IDX_IRQ0;

    mbid_pkg::mbid_state_s q;
    mbid_pkg::mbid_state_s d;

    logic                         isPolicy;
    logic                         isExit;
    logic                         isAFar;
    logic                         isANear;
    logic                         isCFar;
    logic                         isCNear;
    logic [3:0]                   sel;
    logic                         aluHit;
    logic                         ctrlHit;
    logic                         autoAcc;
    logic                         addrPh;
    logic [mbid_pkg::CODE_W-1:0]  seqAddr;
    logic [mbid_pkg::CODE_W-1:0]  nearAddr;
    logic [mbid_pkg::CODE_W-1:0]  farAddr;

    // Offset widened with its sign, sum wraps in the address width
    function automatic logic [mbid_pkg::CODE_W-1:0] relTarget(
        input logic [mbid_pkg::CODE_W-1:0] base,
        input logic [mbid_pkg::F_OFF_W-1:0] off
    );
        logic [mbid_pkg::CODE_W-1:0] ext;
        ext = {{(mbid_pkg::CODE_W - mbid_pkg::F_OFF_W){off[4]}}, off};
        return base + ext;
    endfunction : relTarget

    function automatic logic [31:0] readReg(
        input logic [9:0]            idx,
        input mbid_pkg::mbid_state_s s
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx == CTRL_IDX) begin
            v = {16'h0000, s.ctrlBits};
        end else if (idx == RST_IDX) begin
            v = {16'h0000, s.restartAddr};
        end else if (idx == IRQ_IDX) begin
            v = {16'h0000, s.irqState};
        end
        return v;
    endfunction : readReg

    assign isPolicy = instr.valid && instr.word[15:2] == mbid_pkg::PAT_POLICY;
    assign isExit   = instr.valid && instr.word[15:2] == mbid_pkg::PAT_EXIT;
    assign isAFar   = instr.valid && instr.word[15:9] == mbid_pkg::PAT_AFAR
                      && instr.word[3:0] == mbid_pkg::PAT_AFAR_LO;
    assign isANear  = instr.valid && instr.word[15:9] == mbid_pkg::PAT_ANEAR;
    assign isCFar   = instr.valid && instr.word[15:10] == mbid_pkg::PAT_CFAR
                      && instr.word[3:0] == mbid_pkg::PAT_CFAR_LO;
    assign isCNear  = instr.valid && instr.word[15:10] == mbid_pkg::PAT_CNEAR;

    assign sel      = instr.word[mbid_pkg::F_SEL_LSB +: 4];
    // Selector code equals the flag's position in the condition word
    assign aluHit   = aluCond[sel];
    assign ctrlHit  = q.ctrlBits[sel] == instr.word[mbid_pkg::F_POL_BIT];

    assign seqAddr  = instr.addr + 10'h001;
    assign nearAddr = relTarget(instr.addr, instr.word[4:0]);
    assign farAddr  = jumpRegs[instr.word[mbid_pkg::F_OP1_BIT]];

    // Policy 01 has bit 1 clear, so it is ignored like 00
    assign autoAcc  = irqReturnReq && q.policy[1];
    assign addrPh   = hsel && htrans[1] && hready;

    always_comb begin
        d          = q;
        d.pcLoad   = 1'b0;
        d.flush    = 1'b0;
        d.retTaken = 1'b0;
        d.hready   = 1'b1;
        // The return request preempts the instruction in the same cycle
        if (autoAcc) begin
            d.pcLoad   = 1'b1;
            d.retTaken = 1'b1;
            d.irqState = 16'h0000;
            if (q.policy == mbid_pkg::POLICY_RSTRT) begin
                d.pcNext = q.restartAddr[mbid_pkg::CODE_W-1:0];
            end else begin
                d.pcNext = q.irqState[mbid_pkg::CODE_W-1:0];
            end
        end else if (instr.valid) begin
            d.pcLoad = 1'b1;
            d.pcNext = seqAddr;
            if (isPolicy) begin
                d.policy = instr.word[1:0];
            end else if (isExit) begin
                d.irqState = 16'h0000;
                d.retTaken = 1'b1;
                d.flush    = instr.word[mbid_pkg::F_FLUSH_BIT];
                if (instr.word[mbid_pkg::F_RESUME_BIT]) begin
                    d.pcNext = q.restartAddr[mbid_pkg::CODE_W-1:0];
                end else begin
                    d.pcNext = q.irqState[mbid_pkg::CODE_W-1:0];
                end
            end else if (isAFar && aluHit) begin
                d.pcNext = farAddr;
            end else if (isANear && aluHit) begin
                d.pcNext = nearAddr;
            end else if (isCFar && ctrlHit) begin
                d.pcNext = farAddr;
            end else if (isCNear && ctrlHit) begin
                d.pcNext = nearAddr;
            end
        end
        // Bus data phase; the interrupt state is read only
        if (q.wrPend) begin
            if (q.wrIdx == CTRL_IDX) begin
                d.ctrlBits = hwdata[15:0];
            end else if (q.wrIdx == RST_IDX) begin
                d.restartAddr = hwdata[15:0];
            end
        end
        d.wrPend = addrPh && hwrite;
        d.wrIdx  = haddr[11:2];
        d.hrdata = 32'h0000_0000;
        if (addrPh && !hwrite && haddr[31:12] == 20'h00000) begin
            d.hrdata = readReg(haddr[11:2], q);
        end
        // Entry after the clear so a new interrupt is never lost
        if (irqEnter) begin
            d.irqState = irqEnterState;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q.policy      <= mbid_pkg::RST_POLICY;
            q.irqState    <= mbid_pkg::RST_IRQ;
            q.ctrlBits    <= mbid_pkg::RST_CTRL;
            q.restartAddr <= mbid_pkg::RST_RESTART;
            q.pcLoad      <= 1'b0;
            q.pcNext      <= '0;
            q.flush       <= 1'b0;
            q.retTaken    <= 1'b0;
            q.wrPend      <= 1'b0;
            q.wrIdx       <= 10'h000;
            q.hrdata      <= 32'h0000_0000;
            q.hready      <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hreadyout    = q.hready;
    assign hresp        = 1'b0;
    assign hrdata       = q.hrdata;
    assign pcLoad       = q.pcLoad;
    assign pcNext       = q.pcNext;
    assign queueFlush   = q.flush;
    assign returnTaken  = q.retTaken;
    assign returnPolicy = q.policy;
    assign controlBits  = q.ctrlBits;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic plainExit;
    assign plainExit = isExit && !autoAcc && !irqEnter;

    property p_ignore_none;
        irqReturnReq && q.policy == mbid_pkg::POLICY_NONE && !instr.valid
            |=> !pcLoad && !returnTaken;
    endproperty
    a_ignore_none: assert property (p_ignore_none)
        else $error("return request not ignored under policy none");

    sequence s_cont_policy;
        q.policy == mbid_pkg::POLICY_CONT;
    endsequence
    sequence s_bare_request;
        irqReturnReq && !irqEnter && !q.wrPend;
    endsequence
    property p_auto_continue;
        logic [9:0] st;
        (s_cont_policy ##0 s_bare_request, st = q.irqState[9:0])
            |=> pcLoad && returnTaken && pcNext == st;
    endproperty
    a_auto_continue: assert property (p_auto_continue)
        else $error("continue policy did not resume at saved address");

    property p_auto_restart;
        irqReturnReq && q.policy == mbid_pkg::POLICY_RSTRT
            |=> pcLoad && pcNext == $past(q.restartAddr[9:0]) && q.irqState == 16'h0000
                || $past(irqEnter);
    endproperty
    a_auto_restart: assert property (p_auto_restart)
        else $error("restart policy did not load restart address");

    property p_policy_store;
        isPolicy && !autoAcc |=> returnPolicy == $past(instr.word[1:0]);
    endproperty
    a_policy_store: assert property (p_policy_store)
        else $error("policy field not stored");

    property p_exit_clear;
        plainExit |=> q.irqState == 16'h0000 && returnTaken;
    endproperty
    a_exit_clear: assert property (p_exit_clear)
        else $error("interrupt exit left state uncleared");

    property p_exit_resume;
        logic [9:0] st;
        logic [9:0] ra;
        (plainExit, st = q.irqState[9:0], ra = q.restartAddr[9:0])
            |=> pcLoad && pcNext == ($past(instr.word[1]) ? ra : st);
    endproperty
    a_exit_resume: assert property (p_exit_resume)
        else $error("interrupt exit resumed at wrong address");

    property p_exit_flush;
        isExit && !autoAcc |=> queueFlush == $past(instr.word[0]);
    endproperty
    a_exit_flush: assert property (p_exit_flush)
        else $error("queue flush does not follow flush bit");

    property p_far_alu;
        isAFar && !autoAcc
            |=> pcNext == ($past(aluCond[instr.word[mbid_pkg::F_SEL_LSB +: 4]])
                           ? $past(jumpRegs[instr.word[mbid_pkg::F_OP1_BIT]])
                           : $past(instr.addr) + 10'h001);
    endproperty
    a_far_alu: assert property (p_far_alu)
        else $error("far arithmetic jump target wrong");

    property p_near_alu;
        isANear && !autoAcc && aluHit
            |=> pcNext == $past(instr.addr) + {{5{$past(instr.word[4])}}, $past(instr.word[4:0])};
    endproperty
    a_near_alu: assert property (p_near_alu)
        else $error("near arithmetic jump target wrong");

    property p_ctrl_cond;
        (isCFar || isCNear) && !autoAcc
            && (controlBits[sel] != instr.word[mbid_pkg::F_POL_BIT])
            |=> pcLoad && pcNext == $past(instr.addr) + 10'h001 && !queueFlush;
    endproperty
    a_ctrl_cond: assert property (p_ctrl_cond)
        else $error("false control condition did not fall through");

    property p_ctrl_near;
        isCNear && !autoAcc && controlBits[sel] == instr.word[mbid_pkg::F_POL_BIT]
            |=> pcNext == $past(instr.addr) + {{5{$past(instr.word[4])}}, $past(instr.word[4:0])}
                && !returnTaken;
    endproperty
    a_ctrl_near: assert property (p_ctrl_near)
        else $error("near control jump not taken");

endmodule : mbid_branch_irq_decode

// *** tb/mbid_core_model.sv ***
/*
 Core-side partner: program counter that follows pcLoad and issues one
 instruction word at the counter's address. Assumes the bench raises
 issue for a single cycle and waits for the load before the next one.
*/
module mbid_core_model (
    input  wire logic                        clock,
    input  wire logic                        reset,
    input  wire logic                        issue,
    input  wire logic [15:0]                 word,
    input  wire logic                        pcLoad,
    input  wire logic [mbid_pkg::CODE_W-1:0] pcNext,
    output mbid_pkg::mbid_instr_s            instr,
    output logic [mbid_pkg::CODE_W-1:0]      pc
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] lastWord;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pc       <= '0;
            lastWord <= 16'h0000;
        end else begin
            if (pcLoad)
                pc <= pcNext;
            if (issue)
                lastWord <= word;
        end
    end

    // Idle bus shows inverted data so a stale word never passes as valid
    always_comb begin
        instr.valid = issue;
        instr.word  = issue ? word : ~lastWord;
        instr.addr  = pc;
    end
endmodule : mbid_core_model

// *** tb/mbid_branch_irq_decode_tb.sv ***
/*
 Self-checking bench for the branch and interrupt-return decoder.
 Assumes core 0 register indices; bus waits follow hreadyout.
*/
module mbid_branch_irq_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        clock, reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0]                 haddr, hwdata, hrdata, rd;
    logic [1:0]                  htrans, returnPolicy;
    logic                        irqReturnReq, irqEnter, issue;
    logic                        pcLoad, queueFlush, returnTaken;
    logic [15:0]                 irqEnterState, controlBits, word;
    logic [9:0]                  pcNext, pc, expPc;
    logic [1:0][9:0]             jumpRegs;
    mbid_pkg::mbid_alu_cond_s    aluCond;
    mbid_pkg::mbid_instr_s       instr;
    int                          n_fail, check_count, cycles;

    mbid_branch_irq_decode u_dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr(instr),
        .aluCond(aluCond), .jumpRegs(jumpRegs), .irqReturnReq(irqReturnReq),
        .irqEnter(irqEnter), .irqEnterState(irqEnterState), .pcLoad(pcLoad),
        .pcNext(pcNext), .queueFlush(queueFlush), .returnTaken(returnTaken),
        .returnPolicy(returnPolicy), .controlBits(controlBits));

    mbid_core_model u_core (.clock(clock), .reset(reset), .issue(issue), .word(word),
        .pcLoad(pcLoad), .pcNext(pcNext), .instr(instr), .pc(pc));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic step;
        @(posedge clock);
        #1;
    endtask : step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [9:0] rel(input logic [9:0] b, input logic [4:0] o);
        rel = b + {{5{o[4]}}, o};
    endfunction : rel

    task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {20'h00000, idx, 2'b00};
        hwrite <= wr;
        // Address phase held until hready is seen high at an edge
        do
            @(posedge clock);
        while (hreadyout !== 1'b1);
        #1;
        htrans <= 2'b00;
        hwdata <= {16'h0000, wd};
        do
            @(posedge clock);
        while (hreadyout !== 1'b1);
        // Read data taken at the edge that ends the data phase
        rd = hrdata;
        #1;
        // Select stays up; IDLE between calls is ignored by the slave
    endtask : bus

    task automatic exec(input logic [15:0] w, input logic [9:0] tgt, input logic rt,
                        input logic qf);
        issue <= 1'b1;
        word  <= w;
        step();
        issue <= 1'b0;
        chk(pcLoad, 1'b1);
        chk(pcNext, tgt);
        chk(returnTaken, rt);
        chk(queueFlush, qf);
        expPc = tgt;
        step();
        chk(pc, expPc);
    endtask : exec

    task automatic enter(input logic [15:0] s);
        irqEnter      <= 1'b1;
        irqEnterState <= s;
        step();
        irqEnter <= 1'b0;
    endtask : enter

    task automatic ret_req(input logic expLd, input logic [9:0] tgt);
        irqReturnReq <= 1'b1;
        step();
        irqReturnReq <= 1'b0;
        chk(pcLoad, expLd);
        chk(returnTaken, expLd);
        if (expLd) begin
            chk(pcNext, tgt);
            expPc = tgt;
        end
        step();
    endtask : ret_req

    task automatic set_pol(input logic [1:0] p);
        exec({mbid_pkg::PAT_POLICY, p}, expPc + 10'h001, 1'b0, 1'b0);
        chk(returnPolicy, p);
    endtask : set_pol

    task automatic t_regs;
        chk(controlBits, 16'h0000);
        chk(returnPolicy, 2'h0);
        chk(hresp, 1'b0);
        chk(hreadyout, 1'b1);
        bus(1'b0, mbid_pkg::IDX_RESTART0, 16'h0000);
        chk(rd, 32'h0);
        bus(1'b1, mbid_pkg::IDX_CTRL0, 16'ha5c3);
        bus(1'b0, mbid_pkg::IDX_CTRL0, 16'h0000);
        chk(rd, 32'h0000a5c3);
        chk(controlBits, 16'ha5c3);
        bus(1'b1, mbid_pkg::IDX_RESTART0, 16'h0123);
        bus(1'b0, mbid_pkg::IDX_RESTART0, 16'h0000);
        chk(rd, 32'h00000123);
        // Read-only and unmapped places swallow writes
        bus(1'b1, mbid_pkg::IDX_IRQ0, 16'h1234);
        bus(1'b0, mbid_pkg::IDX_IRQ0, 16'h0000);
        chk(rd, 32'h0);
        bus(1'b1, 10'h100, 16'hffff);
        bus(1'b0, 10'h100, 16'h0000);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_policy;
        set_pol(2'h0);
        enter(16'h0155);
        ret_req(1'b0, 10'h000);
        set_pol(2'h1);
        ret_req(1'b0, 10'h000);
        set_pol(2'h2);
        ret_req(1'b1, 10'h155);
        bus(1'b0, mbid_pkg::IDX_IRQ0, 16'h0000);
        chk(rd, 32'h0);
        set_pol(2'h3);
        enter(16'h0277);
        ret_req(1'b1, 10'h123);
        $display("test policy done");
    endtask : t_policy

    task automatic t_iret;
        logic [15:0] s;
        for (int i = 0; i < 4; i++) begin
            s = {6'h2b, 10'h0d0 + 10'(i)};
            enter(s);
            exec({mbid_pkg::PAT_EXIT, 2'(i)}, i[1] ? 10'h123 : s[9:0], 1'b1, i[0]);
            bus(1'b0, mbid_pkg::IDX_IRQ0, 16'h0000);
            chk(rd, 32'h0);
        end
        $display("test iret done");
    endtask : t_iret

    task automatic t_jumps;
        logic [3:0] sl;
        logic [4:0] off;
        logic [9:0] jr;
        logic       hit;
        jumpRegs <= {10'h3a5, 10'h05a};
        for (int s = 0; s < 16; s++) begin
            for (int k = 0; k < 2; k++) begin
                sl  = 4'(s);
                off = s[0] ? 5'h10 : 5'h0f;
                jr  = s[0] ? 10'h3a5 : 10'h05a;
                aluCond <= k[0] ? ~(16'h0001 << s) : (16'h0001 << s);
                exec({mbid_pkg::PAT_ANEAR, sl, off}, k[0] ? expPc + 10'h001 : rel(expPc, off), 1'b0, 1'b0);
                exec({mbid_pkg::PAT_AFAR, sl, s[0], mbid_pkg::PAT_AFAR_LO}, k[0] ? expPc + 10'h001 : jr, 1'b0, 1'b0);
                hit = (((16'ha5c3 >> s) & 16'h0001) == 16'(k));
                exec({mbid_pkg::PAT_CNEAR, k[0], sl, off}, hit ? rel(expPc, off) : expPc + 10'h001, 1'b0, 1'b0);
                exec({mbid_pkg::PAT_CFAR, k[0], sl, s[0], mbid_pkg::PAT_CFAR_LO}, hit ? jr : expPc + 10'h001, 1'b0, 1'b0);
            end
        end
        $display("test jumps done");
    endtask : t_jumps

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        irqReturnReq = 1'b0;
        irqEnter = 1'b0;
        irqEnterState = 16'h0000;
        issue = 1'b0;
        word = 16'h0000;
        jumpRegs = '0;
        aluCond = '0;
        expPc = 10'h000;
        n_fail = 0;
        check_count = 0;
        cycles = 0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        step();
        t_regs();
        t_policy();
        t_iret();
        t_jumps();
        end_of_test();
    end
endmodule : mbid_branch_irq_decode_tb
